// >>> verilog/afe_regs.svh
// register offsets, field positions, reset values and counts of the
// front-end control block; assumes byte addresses on a 32-bit slave
`ifndef AFE_REGS_SVH
`define AFE_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define AFE_OFF_CTRL 5'h00
`define AFE_OFF_THRESH 5'h04
`define AFE_OFF_PHASE 5'h08
`define AFE_OFF_DRIVER 5'h0C
`define AFE_OFF_STATUS 5'h10

// ****************************************************************
// field positions
// ****************************************************************
`define AFE_CTRL_DC_EN 0
`define AFE_CTRL_CUT_LSB 1
`define AFE_CTRL_GATE_EN 3
`define AFE_CTRL_DIV_LSB 4
`define AFE_CTRL_HOLD_LSB 6
`define AFE_DRV_AMP_LSB 0
`define AFE_DRV_DEM_LSB 4
`define AFE_STAT_OVR_A 0
`define AFE_STAT_OVR_B 1
`define AFE_STAT_RECAL 2
`define AFE_STAT_REINIT 3

// ****************************************************************
// reset values and counts
// ****************************************************************
`define AFE_RST_CTRL 8'h00
`define AFE_RST_THRESH 8'h00
`define AFE_RST_PHASE 4'h0
`define AFE_RST_FIELD3 3'h0
`define AFE_OVR_HALF_STEP_LSB 7
`define AFE_HPF_FRAC 16
`define AFE_HPF_SHIFT_BASE 10
`define AFE_HOLD_3 4'h3
`define AFE_HOLD_7 4'h7
`define AFE_HOLD_15 4'hF

`endif

// >>> verilog/afe_pkg.sv
// types shared by the front-end control block
// assumes afe_regs.svh for all numeric constants
`default_nettype none
package afe_pkg;
	typedef logic signed [15:0] sample_t;
	typedef logic [1:0] cutoff_code_t;
	typedef enum logic [1:0] {DIV_BY_1, DIV_BY_2, DIV_BY_4, DIV_BY_8} div_code_t;
	typedef enum logic [1:0] {HOLD_NONE, HOLD_3, HOLD_7, HOLD_15} hold_code_t;
endpackage : afe_pkg
`default_nettype wire

// >>> verilog/dc_offset_hpf.sv
// dc-removal high-pass filter for one core output stream
// assumes samples arrive as one-cycle valid strobes on i_mclk
`timescale 1ns/10ps
`default_nettype none
`include "afe_regs.svh"
module dc_offset_hpf #(
	parameter int FRAC = `AFE_HPF_FRAC,
	parameter int SHIFT_BASE = `AFE_HPF_SHIFT_BASE
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_enable,
	input wire afe_pkg::cutoff_code_t i_cutoff,
	input wire logic i_valid,
	input wire afe_pkg::sample_t i_sample,
	output logic o_valid,
	output afe_pkg::sample_t o_sample
);
	import afe_pkg::*;
	localparam int ACC_W = 17 + FRAC;
	if (SHIFT_BASE < 1 || SHIFT_BASE + 6 > FRAC) begin : g_bad_shift
		$error("dc_offset_hpf: shift range exceeds fraction width");
	end
	logic signed [ACC_W-1:0] dc_reg;
	logic signed [ACC_W-1:0] x_ext;
	logic signed [ACC_W-1:0] step;
	logic signed [17:0] diff;
	sample_t sat;

	// first-order tracker of the dc level; output is input minus it
	always_comb begin
		x_ext = {i_sample[15], i_sample, {FRAC{1'b0}}};
		step = (x_ext - dc_reg) >>> (SHIFT_BASE + 2 * int'(i_cutoff)); // R3
		diff = {{2{i_sample[15]}}, i_sample} - {dc_reg[ACC_W-1], dc_reg[ACC_W-1:FRAC]};
		if (diff > 18'sh07FFF) begin
			sat = 16'sh7FFF;
		end else if (diff < -18'sh08000) begin
			sat = -16'sh8000;
		end else begin
			sat = diff[15:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_enable) begin
			dc_reg <= '0; // R1
		end else if (i_valid) begin
			dc_reg <= dc_reg + step; // R2
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_valid <= 1'b0;
			o_sample <= '0;
		end else begin
			o_valid <= i_valid;
			if (i_valid) begin
				o_sample <= i_enable ? sat : i_sample; // R1 R2
			end
		end
	end

	a_hpf_bypass: assert property (@(posedge i_mclk) disable iff (i_rst) // R1
		!i_enable && i_valid |=> o_valid && o_sample == $past(i_sample))
		else $error("bypassed filter altered a sample");
	a_hpf_idle_clear: assert property (@(posedge i_mclk) disable iff (i_rst) // R2
		!i_enable |=> dc_reg == '0)
		else $error("dc tracker not cleared while bypassed");
endmodule : dc_offset_hpf
`default_nettype wire

// >>> verilog/overrange_detect.sv
// over-range window compare and hold counter for one channel
// assumes a one-cycle frame tick and raw core samples on i_mclk
`timescale 1ns/10ps
`default_nettype none
`include "afe_regs.svh"
module overrange_detect (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire afe_pkg::sample_t i_sample,
	input wire logic [7:0] i_step,
	input wire afe_pkg::hold_code_t i_hold,
	input wire logic i_frame_tick,
	output logic o_flag
);
	import afe_pkg::*;
	localparam logic signed [16:0] FULL_HI = 17'sh07FFF;
	localparam logic signed [16:0] FULL_LO = -17'sh08000;
	logic signed [16:0] shrink;
	logic signed [16:0] s_ext;
	logic over;
	logic [3:0] hold_len;
	logic [3:0] cnt_reg;

	// each step narrows the window by half a step on each side
	always_comb begin
		shrink = 17'(i_step) <<< `AFE_OVR_HALF_STEP_LSB; // R5 R22
		s_ext = {i_sample[15], i_sample};
		over = (s_ext > FULL_HI - shrink) || (s_ext < FULL_LO + shrink); // R21
		case (i_hold)
			HOLD_3: hold_len = `AFE_HOLD_3; // R7
			HOLD_7: hold_len = `AFE_HOLD_7;
			HOLD_15: hold_len = `AFE_HOLD_15;
			default: hold_len = 4'h0; // R8
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_flag <= 1'b0;
			cnt_reg <= 4'h0;
		end else if (over) begin
			o_flag <= 1'b1; // R4
			cnt_reg <= 4'h0;
		end else if (o_flag) begin
			if (cnt_reg >= hold_len) begin
				o_flag <= 1'b0; // R6
				cnt_reg <= 4'h0;
			end else if (i_frame_tick) begin
				cnt_reg <= cnt_reg + 4'h1; // R6 R9
			end
		end
	end

	a_ovr_raise: assert property (@(posedge i_mclk) disable iff (i_rst) // R4
		over |=> o_flag)
		else $error("over-range sample did not raise flag");
	a_ovr_release: assert property (@(posedge i_mclk) disable iff (i_rst) // R6
		$fell(o_flag) |-> $past(cnt_reg) == $past(hold_len))
		else $error("flag fell before hold count reached");
	a_ovr_nohold: assert property (@(posedge i_mclk) disable iff (i_rst) // R8
		i_hold == HOLD_NONE && o_flag && !over |=> !o_flag)
		else $error("flag held with zero hold setting");
endmodule : overrange_detect
`default_nettype wire

// >>> verilog/adc_frontend_digital_control.sv
// top of the converter front-end digital control with avalon-mm regs
// assumes core samples on i_mclk; reference pulse is asynchronous
//
// Overview of operation
// (R1) offset filter bypassed after reset until software enables it
// (R2) enabled filter is a high-pass iir on each core output
// (R3) four selectable low-frequency cutoff choices
// (R4) per-channel over-range pin rises on raw input, no pipeline delay
// (R5) threshold from full range down to plus/minus 128 in 255 steps
// (R6) hold counter starts when signal returns; flag falls at count
// (R7) hold selectable as 3, 7 or 15 frame cycles
// (R8) hold is zero after reset, flag falls at once
// (R9) independent hold counters, one shared hold setting
// (R10) device clock divided by 1, 2, 4 or 8 to sample rate
// (R11) new divider value restarts link; recalibrate if rate differs
// (R12) reference gate ands pulse with enable, blocking all edges
// (R13) gate disabled after reset, edges ignored until enabled
// (R14) outside source keeps pulse idle when best spurs are needed
// (R15) coarse phase step is half a device clock, 2 x divider positions
// (R16) one phase setting serves both channels
// (R17) phase change leaves frame clock and output data undisturbed
// (R18) latency changes by the phase change, frame timing fixed
// (R19) sampling phase realigned on every gated reference pulse
// (R20) eight amplitude and eight de-emphasis settings, set separately
// (R21) sample outside programmed symmetric window flags its channel
// (R22) window shrinks 256 codes per step, half on each side
`timescale 1ns/10ps
`default_nettype none
`include "afe_regs.svh"
module adc_frontend_digital_control (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire afe_pkg::sample_t i_core_a_sample,
	input wire afe_pkg::sample_t i_core_b_sample,
	input wire logic i_ref_pulse,
	input wire logic i_cal_done,
	output logic o_overrange_flag_chan_a,
	output logic o_overrange_flag_chan_b,
	output logic o_sample_strobe,
	output logic o_sample_half_step,
	output logic o_frame_strobe,
	output afe_pkg::sample_t o_chan_a_data,
	output afe_pkg::sample_t o_chan_b_data,
	output logic [3:0] o_input_clock_divide_factor,
	output logic o_link_reinit,
	output logic o_recal_needed,
	output logic [2:0] o_driver_amplitude_setting,
	output logic [2:0] o_driver_deemphasis_setting
);
	import afe_pkg::*;
	localparam logic [7:0] RST_CTRL = `AFE_RST_CTRL;

	// ****************************************************************
	// control registers and bus slave
	// ****************************************************************
	logic ack_reg;
	logic wr_en;
	logic rd_take;
	logic [2:0] word_idx;
	logic dc_en_reg;
	cutoff_code_t cutoff_reg;
	logic gate_en_reg;
	div_code_t div_reg;
	hold_code_t hold_reg;
	logic [7:0] thresh_reg;
	logic [3:0] phase_reg;
	logic [2:0] amp_reg;
	logic [2:0] dem_reg;
	logic reinit_flag_reg;
	div_code_t cal_div_reg;
	logic [31:0] read_mux;
	logic wr_ctrl;
	logic wr_phase;
	logic div_restart;

	// every access waits exactly one cycle, then completes
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
	assign wr_en = i_avs_write && ack_reg && i_avs_byteenable[0];
	assign rd_take = i_avs_read && !ack_reg;
	assign word_idx = i_avs_address[4:2];
	assign wr_ctrl = wr_en && word_idx == `AFE_OFF_CTRL >> 2;
	assign wr_phase = wr_en && word_idx == `AFE_OFF_PHASE >> 2;
	assign div_restart = wr_ctrl &&
		i_avs_writedata[`AFE_CTRL_DIV_LSB +: 2] != div_reg;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			dc_en_reg <= RST_CTRL[`AFE_CTRL_DC_EN]; // R1
			cutoff_reg <= RST_CTRL[`AFE_CTRL_CUT_LSB +: 2];
			gate_en_reg <= RST_CTRL[`AFE_CTRL_GATE_EN]; // R13
			div_reg <= DIV_BY_1;
			hold_reg <= HOLD_NONE; // R8
		end else if (wr_ctrl) begin
			dc_en_reg <= i_avs_writedata[`AFE_CTRL_DC_EN]; // R1
			cutoff_reg <= i_avs_writedata[`AFE_CTRL_CUT_LSB +: 2]; // R3
			gate_en_reg <= i_avs_writedata[`AFE_CTRL_GATE_EN]; // R12
			div_reg <= div_code_t'(i_avs_writedata[`AFE_CTRL_DIV_LSB +: 2]); // R10
			hold_reg <= hold_code_t'(i_avs_writedata[`AFE_CTRL_HOLD_LSB +: 2]); // R7 R9
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			thresh_reg <= `AFE_RST_THRESH;
			phase_reg <= `AFE_RST_PHASE;
			amp_reg <= `AFE_RST_FIELD3;
			dem_reg <= `AFE_RST_FIELD3;
		end else if (wr_en) begin
			if (word_idx == `AFE_OFF_THRESH >> 2) begin
				thresh_reg <= i_avs_writedata[7:0]; // R5
			end
			if (wr_phase) begin
				phase_reg <= i_avs_writedata[3:0]; // R15 R16
			end
			if (word_idx == `AFE_OFF_DRIVER >> 2) begin
				amp_reg <= i_avs_writedata[`AFE_DRV_AMP_LSB +: 3]; // R20
				dem_reg <= i_avs_writedata[`AFE_DRV_DEM_LSB +: 3]; // R20
			end
		end
	end

	// sticky restart request: a new restart beats a clear in the same cycle
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			reinit_flag_reg <= 1'b0;
		end else if (div_restart) begin
			reinit_flag_reg <= 1'b1; // R11
		end else if (wr_en && word_idx == `AFE_OFF_STATUS >> 2 &&
				i_avs_writedata[`AFE_STAT_REINIT]) begin
			reinit_flag_reg <= 1'b0;
		end
	end

	// divider in force at the last finished calibration
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cal_div_reg <= DIV_BY_1;
		end else if (i_cal_done) begin
			cal_div_reg <= div_reg; // R11
		end
	end

	always_comb begin
		read_mux = 32'h00000000;
		case (word_idx)
			`AFE_OFF_CTRL >> 2: begin
				read_mux[`AFE_CTRL_DC_EN] = dc_en_reg;
				read_mux[`AFE_CTRL_CUT_LSB +: 2] = cutoff_reg;
				read_mux[`AFE_CTRL_GATE_EN] = gate_en_reg;
				read_mux[`AFE_CTRL_DIV_LSB +: 2] = div_reg;
				read_mux[`AFE_CTRL_HOLD_LSB +: 2] = hold_reg;
			end
			`AFE_OFF_THRESH >> 2: read_mux[7:0] = thresh_reg;
			`AFE_OFF_PHASE >> 2: read_mux[3:0] = phase_reg;
			`AFE_OFF_DRIVER >> 2: begin
				read_mux[`AFE_DRV_AMP_LSB +: 3] = amp_reg;
				read_mux[`AFE_DRV_DEM_LSB +: 3] = dem_reg;
			end
			`AFE_OFF_STATUS >> 2: begin
				read_mux[`AFE_STAT_OVR_A] = o_overrange_flag_chan_a;
				read_mux[`AFE_STAT_OVR_B] = o_overrange_flag_chan_b;
				read_mux[`AFE_STAT_RECAL] = o_recal_needed;
				read_mux[`AFE_STAT_REINIT] = reinit_flag_reg;
			end
			default: read_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_avs_readdata <= 32'h00000000;
		end else if (rd_take) begin
			o_avs_readdata <= read_mux;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_link_reinit <= 1'b0;
			o_recal_needed <= 1'b0;
			o_driver_amplitude_setting <= `AFE_RST_FIELD3;
			o_driver_deemphasis_setting <= `AFE_RST_FIELD3;
		end else begin
			o_link_reinit <= div_restart; // R11
			o_recal_needed <= div_reg != cal_div_reg; // R11
			o_driver_amplitude_setting <= amp_reg; // R20
			o_driver_deemphasis_setting <= dem_reg; // R20
		end
	end

	// ****************************************************************
	// reference pulse synchroniser and detection gate
	// ****************************************************************
	logic ref_s1_reg;
	logic ref_s2_reg;
	logic ref_s3_reg;
	logic ref_level_reg;
	logic ref_rise;
	logic ref_event;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ref_s1_reg <= 1'b0;
			ref_s2_reg <= 1'b0;
			ref_s3_reg <= 1'b0;
		end else begin
			ref_s1_reg <= i_ref_pulse;
			ref_s2_reg <= ref_s1_reg;
			ref_s3_reg <= ref_s2_reg;
		end
	end

	// level accepted only once two stages agree
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ref_level_reg <= 1'b0;
		end else if (ref_s2_reg == ref_s3_reg) begin
			ref_level_reg <= ref_s3_reg;
		end
	end

	assign ref_rise = ref_s2_reg && ref_s3_reg && !ref_level_reg;
	assign ref_event = ref_rise && gate_en_reg; // R12 R13

	// ****************************************************************
	// clock divider, coarse phase and frame timing
	// ****************************************************************
	logic [3:0] div_n;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic [4:0] pos_mask;
	logic [3:0] phase_eff;
	logic sample_tick;
	logic frame_tick;

	always_comb begin
		div_n = 4'h1 << div_reg; // R10
		pos_mask = 5'({div_n, 1'b0} - 5'h01); // R15
		phase_eff = phase_reg & pos_mask[3:0];
		cnt_next = (cnt_reg >= 3'(div_n - 4'h1)) ? 3'h0 : cnt_reg + 3'h1;
		sample_tick = cnt_reg == phase_eff[3:1]; // R15 R16
		frame_tick = cnt_reg == 3'h0; // R18
	end

	// phase writes never touch this counter, so frames keep their cadence
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cnt_reg <= 3'h0;
		end else if (ref_event || div_restart) begin
			cnt_reg <= 3'h0; // R19 R11
		end else begin
			cnt_reg <= cnt_next; // R17
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_sample_strobe <= 1'b0;
			o_sample_half_step <= 1'b0;
			o_frame_strobe <= 1'b0;
			o_input_clock_divide_factor <= 4'h1;
		end else begin
			o_sample_strobe <= sample_tick; // R16
			o_sample_half_step <= phase_eff[0]; // R15
			o_frame_strobe <= frame_tick;
			o_input_clock_divide_factor <= div_n; // R10
		end
	end

	// ****************************************************************
	// sample path: offset filter, retiming into the frame
	// ****************************************************************
	sample_t hpf_a;
	sample_t hpf_b;
	logic hpf_a_valid;
	logic hpf_b_valid;
	sample_t held_a_reg;
	sample_t held_b_reg;

	dc_offset_hpf u_hpf_a (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_enable(dc_en_reg),
		.i_cutoff(cutoff_reg),
		.i_valid(sample_tick),
		.i_sample(i_core_a_sample),
		.o_valid(hpf_a_valid),
		.o_sample(hpf_a)
	);

	dc_offset_hpf u_hpf_b (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_enable(dc_en_reg),
		.i_cutoff(cutoff_reg),
		.i_valid(sample_tick),
		.i_sample(i_core_b_sample),
		.o_valid(hpf_b_valid),
		.o_sample(hpf_b)
	);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			held_a_reg <= '0;
			held_b_reg <= '0;
		end else begin
			if (hpf_a_valid) begin
				held_a_reg <= hpf_a;
			end
			if (hpf_b_valid) begin
				held_b_reg <= hpf_b;
			end
		end
	end

	// retime at the frame edge so sampling phase only moves latency
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_chan_a_data <= '0;
			o_chan_b_data <= '0;
		end else if (frame_tick) begin
			o_chan_a_data <= held_a_reg; // R17 R18
			o_chan_b_data <= held_b_reg;
		end
	end

	// ****************************************************************
	// over-range detection, both channels on shared settings
	// ****************************************************************
	overrange_detect u_ovr_a (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_sample(i_core_a_sample),
		.i_step(thresh_reg),
		.i_hold(hold_reg),
		.i_frame_tick(frame_tick),
		.o_flag(o_overrange_flag_chan_a)
	);

	overrange_detect u_ovr_b (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_sample(i_core_b_sample),
		.i_step(thresh_reg),
		.i_hold(hold_reg),
		.i_frame_tick(frame_tick),
		.o_flag(o_overrange_flag_chan_b)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_bus_req;
		(i_avs_read || i_avs_write) && !ack_reg;
	endsequence

	sequence s_bus_done;
		!o_avs_waitrequest;
	endsequence

	a_bus_one_wait: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_bus_req |-> o_avs_waitrequest ##1 s_bus_done)
		else $error("bus access not completed after one wait");
	a_reset_defaults: assert property (@(posedge i_mclk) // R1
		i_rst |=> !dc_en_reg && !gate_en_reg && hold_reg == HOLD_NONE)
		else $error("control defaults wrong after reset");
	a_gate_blocks: assert property (@(posedge i_mclk) disable iff (i_rst) // R12
		!gate_en_reg && ref_rise |=> cnt_reg == $past(cnt_next) ||
			$past(div_restart))
		else $error("blocked reference edge moved the phase");
	a_ref_realign: assert property (@(posedge i_mclk) disable iff (i_rst) // R19
		ref_event |=> cnt_reg == 3'h0 ##1 o_frame_strobe)
		else $error("reference event did not realign timing");
	a_phase_steady: assert property (@(posedge i_mclk) disable iff (i_rst) // R17
		wr_phase && !ref_event && !div_restart |=> cnt_reg == $past(cnt_next))
		else $error("phase write disturbed frame counter");
	a_sample_phase: assert property (@(posedge i_mclk) disable iff (i_rst) // R15
		o_sample_strobe |-> $past(cnt_reg) == $past(phase_eff[3:1]))
		else $error("sample strobe off its phase position");
	a_div_restart: assert property (@(posedge i_mclk) disable iff (i_rst) // R11
		div_restart |=> o_link_reinit && reinit_flag_reg && cnt_reg == 3'h0)
		else $error("divider change did not restart link");
	a_retime_frame: assert property (@(posedge i_mclk) disable iff (i_rst) // R18
		frame_tick |=> o_chan_a_data == $past(held_a_reg) &&
			o_chan_b_data == $past(held_b_reg))
		else $error("frame data not retimed from held sample");
	a_window_edge: assert property (@(posedge i_mclk) disable iff (i_rst) // R22
		thresh_reg == 8'hFF && i_core_a_sample == 16'sh0080 |=>
			o_overrange_flag_chan_a)
		else $error("narrowest window did not flag code 128");
	a_driver_out: assert property (@(posedge i_mclk) disable iff (i_rst) // R20
		wr_en && word_idx == `AFE_OFF_DRIVER >> 2 |=> ##1
			o_driver_amplitude_setting == $past(i_avs_writedata[2:0], 2))
		else $error("amplitude setting not driven out");
endmodule : adc_frontend_digital_control
`default_nettype wire

// >>> testbench/host_model.sv
// controller stand-in: avalon master and calibration pulse source
// assumes the slave shares i_mclk and answers with waitrequest
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic i_mclk,
	input wire logic i_waitrequest,
	input wire logic [31:0] i_readdata,
	output logic [4:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata,
	output logic [3:0] o_byteenable,
	output logic o_cal_done
);
	// ****
	// bus cycle, held until waitrequest seen low
	// ****
	initial begin
		o_address = '0;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = '0;
		o_byteenable = '0;
		o_cal_done = 1'b0;
	end

	task xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge i_mclk);
		o_address <= a;
		o_read <= !w;
		o_write <= w;
		o_writedata <= d;
		o_byteenable <= be;
		do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
		q = i_readdata;
		o_read <= 1'b0;
		o_write <= 1'b0;
	endtask : xfer

	// recalibration done after a rate change
	task recal();
		@(posedge i_mclk);
		o_cal_done <= 1'b1;
		@(posedge i_mclk);
		o_cal_done <= 1'b0;
	endtask : recal
endmodule : host_model
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench of the front-end control block
// assumes host_model as bus master and calibration source
`timescale 1ns/10ps
`default_nettype none
`include "afe_regs.svh"
module tb_top;
	import afe_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic i_ref_pulse = 1'b0;
	sample_t i_core_a_sample = '0;
	sample_t i_core_b_sample = '0;
	logic [4:0] i_avs_address;
	logic i_avs_read, i_avs_write, i_cal_done, o_avs_waitrequest;
	logic [31:0] i_avs_writedata, o_avs_readdata, q;
	logic [3:0] i_avs_byteenable, o_input_clock_divide_factor;
	logic o_overrange_flag_chan_a, o_overrange_flag_chan_b, o_sample_strobe;
	logic o_sample_half_step, o_frame_strobe, o_link_reinit, o_recal_needed;
	sample_t o_chan_a_data, o_chan_b_data;
	logic [2:0] o_driver_amplitude_setting, o_driver_deemphasis_setting;
	int error_cnt = 0, comparisons = 0, cyc = 0, last_frame = 0;
	int last_smp = 0, nframe = 0, nreinit = 0, n0, f0, k, p, s, n, lim;

	always #25 i_mclk = ~i_mclk;

	host_model host (.i_mclk, .i_waitrequest(o_avs_waitrequest),
		.i_readdata(o_avs_readdata), .o_address(i_avs_address),
		.o_read(i_avs_read), .o_write(i_avs_write),
		.o_writedata(i_avs_writedata), .o_byteenable(i_avs_byteenable),
		.o_cal_done(i_cal_done));

	adc_frontend_digital_control uut (.i_mclk, .i_rst, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
		.o_avs_readdata, .o_avs_waitrequest, .i_core_a_sample,
		.i_core_b_sample, .i_ref_pulse, .i_cal_done, .o_overrange_flag_chan_a,
		.o_overrange_flag_chan_b, .o_sample_strobe, .o_sample_half_step,
		.o_frame_strobe, .o_chan_a_data, .o_chan_b_data,
		.o_input_clock_divide_factor, .o_link_reinit, .o_recal_needed,
		.o_driver_amplitude_setting, .o_driver_deemphasis_setting);

	// ****
	// strobe timing monitor and helpers
	// ****
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (o_frame_strobe === 1'b1) begin
			last_frame <= cyc;
			nframe <= nframe + 1;
		end
		if (o_sample_strobe === 1'b1)
			last_smp <= cyc;
		if (o_link_reinit === 1'b1)
			nreinit <= nreinit + 1;
	end

	// upper edge of the over-range window for a threshold step
	function automatic int win_lim(input int st);
		return 32767 - 128 * st;
	endfunction : win_lim

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		comparisons++;
		if (seen !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk

	task wr(input logic [4:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, 4'hF, q);
		repeat (2) @(negedge i_mclk);
	endtask : wr

	task pulse(output int pc);
		@(posedge i_mclk);
		i_ref_pulse <= 1'b1;
		pc = cyc;
		repeat (2) @(posedge i_mclk);
		i_ref_pulse <= 1'b0;
		repeat (20) @(negedge i_mclk);
	endtask : pulse

	task summarize();
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	initial begin
		repeat (30000) @(posedge i_mclk);
		error_cnt++;
		summarize();
	end

	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(32'hFB5C));
		repeat (5) @(posedge i_mclk);
		i_rst <= 1'b0;
		host.xfer(1'b0, `AFE_OFF_CTRL, 0, 4'hF, q);
		chk("ctrl", q, 0);
		chk("div", o_input_clock_divide_factor, 1);
		for (int i = 0; i < 8; i++) begin
			n = $urandom_range(7);
			wr(`AFE_OFF_DRIVER, {n[3:0], 1'b0, i[2:0]});
			chk("amp", o_driver_amplitude_setting, i[2:0]);
			chk("dem", o_driver_deemphasis_setting, n[2:0]);
		end
		wr(5'h14, 32'hFF);
		host.xfer(1'b1, `AFE_OFF_CTRL, 32'hFF, 4'hE, q);
		host.xfer(1'b0, 5'h14, 0, 4'hF, q);
		chk("unmapped", q, 0);
		host.xfer(1'b0, `AFE_OFF_CTRL, 0, 4'hF, q);
		chk("ctrl", q, 0);
		for (int c = 3; c >= 0; c--) begin
			wr(`AFE_OFF_CTRL, c << 4);
			chk("div", o_input_clock_divide_factor, 1 << c);
			host.xfer(1'b0, `AFE_OFF_STATUS, 0, 4'hF, q);
			chk("reinit", q[3:2], {1'b1, c > 0});
			wr(`AFE_OFF_STATUS, 8);
			n0 = nframe;
			repeat (32) @(negedge i_mclk);
			chk("frames", nframe - n0, 32 >> c);
		end
		wr(`AFE_OFF_CTRL, 8'h10);
		host.recal();
		repeat (2) @(negedge i_mclk);
		chk("recal", o_recal_needed, 0);
		wr(`AFE_OFF_CTRL, 8'h00);
		chk("recal", o_recal_needed, 1);
		wr(`AFE_OFF_CTRL, 8'h20);
		repeat (10) @(negedge i_mclk);
		f0 = last_frame & 3;
		for (int ph = 0; ph < 8; ph++) begin
			wr(`AFE_OFF_PHASE, ph);
			repeat (8) @(negedge i_mclk);
			chk("smp", (last_smp - last_frame) & 3, ph >> 1);
			chk("half", o_sample_half_step, ph & 1);
			chk("frame", last_frame & 3, f0);
		end
		wr(`AFE_OFF_CTRL, 8'h38);
		pulse(p);
		k = (last_frame - p) & 7;
		repeat (3) @(posedge i_mclk);
		pulse(p);
		chk("realign", (last_frame - p) & 7, k);
		wr(`AFE_OFF_CTRL, 8'h30);
		f0 = last_frame & 7;
		while (((cyc + k - f0) & 7) != 3) @(negedge i_mclk);
		pulse(p);
		chk("blocked", last_frame & 7, f0);
		chk("restarts", nreinit, 8);
		for (int h = 0; h < 4; h++) begin
			s = (h == 0) ? 255 : $urandom_range(254, 1);
			n = (h == 0) ? 0 : (2 << h) - 1;
			lim = win_lim(s);
			wr(`AFE_OFF_THRESH, s);
			wr(`AFE_OFF_CTRL, h << 6);
			@(posedge i_mclk);
			i_core_a_sample <= lim;
			i_core_b_sample <= -lim - 1;
			repeat (3) @(negedge i_mclk);
			chk("edge", {o_overrange_flag_chan_a, o_overrange_flag_chan_b}, 0);
			@(posedge i_mclk);
			i_core_a_sample <= lim + 1;
			i_core_b_sample <= -lim - 2;
			repeat (2) @(posedge i_mclk);
			i_core_a_sample <= '0;
			i_core_b_sample <= '0;
			@(negedge i_mclk);
			chk("over", {o_overrange_flag_chan_a, o_overrange_flag_chan_b}, 3);
			repeat (n) @(negedge i_mclk);
			chk("hold", {o_overrange_flag_chan_a, o_overrange_flag_chan_b}, 3);
			@(negedge i_mclk);
			chk("fall", {o_overrange_flag_chan_a, o_overrange_flag_chan_b}, 0);
		end
		@(posedge i_mclk);
		i_core_a_sample <= 16'h1000;
		i_core_b_sample <= 16'hF000;
		repeat (8) @(negedge i_mclk);
		chk("bypass", o_chan_a_data, 16'h1000);
		chk("bypass_b", $unsigned(o_chan_b_data), 16'hF000);
		wr(`AFE_OFF_CTRL, 8'h07);
		repeat (1000) @(negedge i_mclk);
		chk("slow", o_chan_a_data > 16'sh0800, 1);
		wr(`AFE_OFF_CTRL, 8'h01);
		repeat (8000) @(negedge i_mclk);
		chk("dc", $signed(o_chan_a_data) < 64 && $signed(o_chan_a_data) > -64, 1);
		chk("dc_b", o_chan_b_data < 64 && o_chan_b_data > -64, 1);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
